// ===== include/rcc_pkg.sv
// Package with register map, field layout and timing constants for capture
package rcc_pkg;
  // Register byte offsets
  localparam logic [7:0] RCC_CTRL_OFF = 8'h00;
  localparam logic [7:0] RCC_RLEN_OFF = 8'h04;
  localparam logic [7:0] RCC_PRE_OFF = 8'h08;
  localparam logic [7:0] RCC_RCNT_OFF = 8'h0C;
  localparam logic [7:0] RCC_STAT_OFF = 8'h10;
  localparam logic [7:0] RCC_PFLT_OFF = 8'h14;
  localparam logic [7:0] RCC_AUX_OFF = 8'h18;
  // Control register bits
  localparam int RCC_CTRL_ARM = 0;
  localparam int RCC_CTRL_ABORT = 1;
  localparam int RCC_CTRL_EXTCLK = 2;
  localparam int RCC_CTRL_IDLAMP = 3;
  localparam int RCC_CTRL_MEMOK = 4;
  localparam int RCC_CTRL_TSRC_LSB = 5;
  // Status register bits
  localparam int RCC_ST_ARMED = 0;
  localparam int RCC_ST_TRIG = 1;
  localparam int RCC_ST_CFGERR = 2;
  localparam int RCC_ST_LINK = 3;
  localparam int RCC_ST_LOS = 4;
  localparam int RCC_ST_AUXIN = 5;
  // Record limits
  localparam logic [31:0] RCC_RLEN_MIN = 32'h0000_0080;
  localparam logic [31:0] RCC_RLEN_STEP_MASK = 32'h0000_001F;
  localparam logic [31:0] RCC_PRE_STEP_MASK = 32'h0000_000F;
  localparam logic [31:0] RCC_PRE_MARGIN = 32'h0000_0040;
  localparam logic [31:0] RCC_RCNT_MIN = 32'h0000_0001;
  // Reset values
  localparam logic [31:0] RCC_RLEN_RST = 32'h0000_0080;
  localparam logic [31:0] RCC_RCNT_RST = 32'h0000_0001;
  localparam logic [31:0] RCC_ZERO = 32'h0000_0000;
  // Timing
  localparam int RCC_CLK_HZ = 50_000_000;
  localparam int RCC_BLINK_MS = 250;
  localparam int RCC_CONF_MS = 100;
  localparam int RCC_BLINK_CYC = RCC_CLK_HZ / 1000 * RCC_BLINK_MS;
  localparam int RCC_CONF_CYC = RCC_CLK_HZ / 1000 * RCC_CONF_MS / 2;
  // Trigger sources and aux modes
  typedef enum logic [1:0] {RCC_TS_CHA, RCC_TS_CHB, RCC_TS_EXT, RCC_TS_SW}
    rcc_tsrc_t;
  typedef enum logic [2:0] {RCC_AUX_TRIGOUT, RCC_AUX_PACER, RCC_AUX_DOUT,
    RCC_AUX_TRIGEN, RCC_AUX_DIN} rcc_aux_t;
  localparam int RCC_AUX_LVL = 3;
  localparam int RCC_PACER_LSB = 16;
  localparam int RCC_PACER_W = 16;
endpackage

// ===== logic/rcc_capture_ctrl.sv
// Record capture control: limits, pre-trigger hold-off, indicators, aux I/O
//
// Function
// - Record length at least 128, multiple of 32
// - Collect pre-trigger samples before triggers act
// - Pre-trigger depth fixed for whole session
// - Pre-trigger depth in steps of 16
// - Pre-trigger depth at most length minus 64
// - Record count at least one, no limit
// - Trigger lamp lit during post-trigger capture
// - Armed lamp lit while armed, toggles on re-arm
// - Clock-mode lamp on for internal clock
// - Clock activity lamp blinks while clock runs
// - Config-done lamp on within 100 ms
// - Link lamp lit once link negotiated
// - Memory lamp only after software memory test
// - Oscillator-loss lamp follows oscillator failure
// - Power faults latched until software clear
// - Identification lamp set by software
// - Aux connector selects five I/O functions
// - Trigger input only triggers; channels both
`timescale 1ns/1ns
module rcc_capture_ctrl
  import rcc_pkg::*;
#(
  parameter int CONF_CYC = RCC_CONF_CYC,
  parameter int BLINK_CYC = RCC_BLINK_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Sample stream and trigger sources
  input wire logic sample_valid,
  input wire logic trig_cha,
  input wire logic trig_chb,
  input wire logic external_trigger_input,
  // Board status pins
  input wire logic link_up_pin,
  input wire logic osc_fault_pin,
  input wire logic pwr_fault_a_pin,
  input wire logic pwr_fault_b_pin,
  // Aux connector pin, three signals
  input wire logic aux_in,
  output logic aux_out,
  output logic aux_oe_n,
  // Capture and indicators
  output logic capture_en,
  output logic clock_mode_indicator,
  output logic trigger_capture_indicator,
  output logic clock_activity_indicator,
  output logic armed_indicator,
  output logic config_done_indicator,
  output logic link_up_indicator,
  output logic memory_ok_indicator,
  output logic oscillator_loss_indicator,
  output logic power_fault_indicator_a,
  output logic power_fault_indicator_b,
  output logic id_lamp
);
  typedef enum logic [1:0] {RCC_IDLE, RCC_PRE, RCC_WAIT, RCC_POST} rcc_st_t;

  typedef struct packed {
    logic awr; logic [7:0] awa; logic wr; logic [31:0] wd; logic [3:0] ws;
    logic bv; logic [1:0] br; logic rv; logic [31:0] rd; logic [1:0] rr;
    logic [31:0] ctrl; logic [31:0] rlen; logic [31:0] pre;
    logic [31:0] rcnt; logic [31:0] aux;
    rcc_st_t st; logic [31:0] pre_s; logic [31:0] len_s; logic [31:0] cnt_s;
    logic [31:0] smp; logic [31:0] recs; logic cfgerr; logic armed_led;
    logic trig_led; logic [1:0] pf; logic [31:0] blink; logic blink_led;
    logic [31:0] conf; logic conf_led; logic [15:0] pace; logic pace_o;
    logic aux_o; logic aux_oe_n; logic [5:0] s1; logic [5:0] s2;
    logic cap;
  } rcc_state_t;

  rcc_state_t s_q, s_d;
  logic cfg_ok, trig_hit;

  // Limits check on the live register values
  always_comb begin
    cfg_ok = (s_q.rlen >= RCC_RLEN_MIN) &&
      ((s_q.rlen & RCC_RLEN_STEP_MASK) == RCC_ZERO) &&
      ((s_q.pre & RCC_PRE_STEP_MASK) == RCC_ZERO) &&
      (s_q.pre <= s_q.rlen - RCC_PRE_MARGIN) &&
      (s_q.rcnt >= RCC_RCNT_MIN);
  end

  // Only the two channels or the external input can trigger
  always_comb begin
    unique case (rcc_tsrc_t'(s_q.ctrl[RCC_CTRL_TSRC_LSB +: 2]))
      RCC_TS_CHA: trig_hit = trig_cha;
      RCC_TS_CHB: trig_hit = trig_chb;
      RCC_TS_EXT: trig_hit = s_q.s2[2];
      default: trig_hit = 1'b0;
    endcase
    // Trigger enable on aux gates recognition
    if (rcc_aux_t'(s_q.aux[2:0]) == RCC_AUX_TRIGEN && !s_q.s2[3]) begin
      trig_hit = 1'b0;
    end
  end

  // Next-state logic
  always_comb begin
    s_d = s_q;
    // First stage of every pin synchroniser; only s2 is read elsewhere
    s_d.s1 = {pwr_fault_a_pin, osc_fault_pin, aux_in,
      external_trigger_input, pwr_fault_b_pin, link_up_pin};
    s_d.s2 = s_q.s1;
    // Bit order: 0 link, 1 pwr b, 2 ext trig, 3 aux, 4 osc, 5 pwr a
    s_d.ctrl[RCC_CTRL_ARM] = 1'b0;
    s_d.ctrl[RCC_CTRL_ABORT] = 1'b0;
    // Write channel: accept address and data in either order
    if (s_q.awr == 1'b0 && s_axi_awvalid && !s_q.bv) begin
      s_d.awr = 1'b1;
      s_d.awa = s_axi_awaddr;
    end
    if (s_q.wr == 1'b0 && s_axi_wvalid && !s_q.bv) begin
      s_d.wr = 1'b1;
      s_d.wd = s_axi_wdata;
      s_d.ws = s_axi_wstrb;
    end
    if (s_q.awr && s_q.wr && !s_q.bv) begin
      s_d.awr = 1'b0;
      s_d.wr = 1'b0;
      s_d.bv = 1'b1;
      s_d.br = 2'h0;
      // Full-word writes only; partial strobes leave registers alone
      if (s_q.ws == 4'hF) begin
        case (s_q.awa)
          RCC_CTRL_OFF: s_d.ctrl = s_q.wd;
          RCC_RLEN_OFF: if (s_q.st == RCC_IDLE) s_d.rlen = s_q.wd;
          RCC_PRE_OFF: if (s_q.st == RCC_IDLE) s_d.pre = s_q.wd;
          RCC_RCNT_OFF: if (s_q.st == RCC_IDLE) s_d.rcnt = s_q.wd;
          RCC_PFLT_OFF: s_d.pf = s_q.pf & ~s_q.wd[1:0];
          RCC_AUX_OFF: s_d.aux = s_q.wd;
          RCC_STAT_OFF: s_d.br = 2'h0;
          default: s_d.br = 2'h2;
        endcase
      end
    end
    if (s_q.bv && s_axi_bready) s_d.bv = 1'b0;
    // Read channel
    if (!s_q.rv && s_axi_arvalid) begin
      s_d.rv = 1'b1;
      s_d.rr = 2'h0;
      case (s_axi_araddr)
        RCC_CTRL_OFF: s_d.rd = s_q.ctrl;
        RCC_RLEN_OFF: s_d.rd = s_q.rlen;
        RCC_PRE_OFF: s_d.rd = s_q.pre;
        RCC_RCNT_OFF: s_d.rd = s_q.rcnt;
        RCC_STAT_OFF: s_d.rd = {26'h0, s_q.s2[3], s_q.s2[4], s_q.s2[0],
          s_q.cfgerr, s_q.trig_led, s_q.st != RCC_IDLE};
        RCC_PFLT_OFF: s_d.rd = {30'h0, s_q.pf};
        RCC_AUX_OFF: s_d.rd = s_q.aux;
        default: begin
          s_d.rd = RCC_ZERO;
          s_d.rr = 2'h2;
        end
      endcase
    end
    if (s_q.rv && s_axi_rready) s_d.rv = 1'b0;
    // Power faults latch; set wins over a same-cycle clear
    s_d.pf = s_d.pf | {s_q.s2[1], s_q.s2[5]};
    // Capture sequencer
    s_d.trig_led = 1'b0;
    case (s_q.st)
      RCC_IDLE: begin
        if (s_q.ctrl[RCC_CTRL_ARM]) begin
          if (cfg_ok) begin
            s_d.st = RCC_PRE;
            s_d.cfgerr = 1'b0;
            s_d.pre_s = s_q.pre;
            s_d.len_s = s_q.rlen;
            s_d.cnt_s = s_q.rcnt;
            s_d.recs = RCC_ZERO;
            s_d.smp = RCC_ZERO;
            s_d.armed_led = ~s_q.armed_led;
          end else begin
            s_d.cfgerr = 1'b1;
          end
        end
      end
      RCC_PRE: if (s_q.smp >= s_q.pre_s) s_d.st = RCC_WAIT;
        else if (sample_valid) s_d.smp = s_q.smp + 32'h1;
      RCC_WAIT: begin
        if (sample_valid) s_d.smp = s_q.smp + 32'h1;
        if (trig_hit) begin
          s_d.st = RCC_POST;
          s_d.smp = s_q.pre_s;
        end
      end
      RCC_POST: begin
        s_d.trig_led = 1'b1;
        if (sample_valid) s_d.smp = s_q.smp + 32'h1;
        if (s_q.smp >= s_q.len_s) begin
          s_d.recs = s_q.recs + 32'h1;
          s_d.smp = RCC_ZERO;
          s_d.trig_led = 1'b0; // Gap pulses lamp on repeats
          // Count of all ones runs forever
          if (s_q.recs + 32'h1 == s_q.cnt_s && s_q.cnt_s != 32'hFFFF_FFFF)
            s_d.st = RCC_IDLE;
          else begin
            s_d.st = RCC_PRE;
            s_d.armed_led = ~s_q.armed_led;
          end
        end
      end
      default: s_d.st = RCC_IDLE;
    endcase
    if (s_q.ctrl[RCC_CTRL_ABORT]) s_d.st = RCC_IDLE;
    if (s_d.st == RCC_IDLE) s_d.armed_led = 1'b0;
    else if (s_q.st == RCC_IDLE) s_d.armed_led = 1'b1;
    s_d.cap = s_d.st != RCC_IDLE;
    // Clock activity blink from the running base clock
    if (s_q.blink >= BLINK_CYC - 1) begin
      s_d.blink = RCC_ZERO;
      s_d.blink_led = ~s_q.blink_led;
    end else s_d.blink = s_q.blink + 32'h1;
    // Config-done lamp after a short settle, then held
    if (!s_q.conf_led) begin
      if (s_q.conf >= CONF_CYC - 1) s_d.conf_led = 1'b1;
      else s_d.conf = s_q.conf + 32'h1;
    end
    // Aux connector function
    s_d.aux_oe_n = 1'b0;
    if (s_q.pace >= s_q.aux[RCC_PACER_LSB +: RCC_PACER_W]) begin
      s_d.pace = 16'h0;
      s_d.pace_o = ~s_q.pace_o;
    end else s_d.pace = s_q.pace + 16'h1;
    case (rcc_aux_t'(s_q.aux[2:0]))
      RCC_AUX_TRIGOUT: s_d.aux_o = s_q.trig_led;
      RCC_AUX_PACER: s_d.aux_o = s_q.pace_o;
      RCC_AUX_DOUT: s_d.aux_o = s_q.aux[RCC_AUX_LVL];
      default: begin
        s_d.aux_o = 1'b0;
        s_d.aux_oe_n = 1'b1;
      end
    endcase
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.rlen <= RCC_RLEN_RST;
      s_q.rcnt <= RCC_RCNT_RST;
      s_q.aux_oe_n <= 1'b1;
    end else s_q <= s_d;
  end

  // Output mapping, all from flip-flops
  assign s_axi_awready = s_q.awr == 1'b0 && !s_q.bv;
  assign s_axi_wready = s_q.wr == 1'b0 && !s_q.bv;
  assign s_axi_bvalid = s_q.bv;
  assign s_axi_bresp = s_q.br;
  assign s_axi_arready = !s_q.rv;
  assign s_axi_rvalid = s_q.rv;
  assign s_axi_rdata = s_q.rd;
  assign s_axi_rresp = s_q.rr;
  assign capture_en = s_q.cap;
  assign clock_mode_indicator = ~s_q.ctrl[RCC_CTRL_EXTCLK];
  assign trigger_capture_indicator = s_q.trig_led;
  assign clock_activity_indicator = s_q.blink_led;
  assign armed_indicator = s_q.armed_led;
  assign config_done_indicator = s_q.conf_led;
  assign link_up_indicator = s_q.s2[0];
  assign memory_ok_indicator = s_q.ctrl[RCC_CTRL_MEMOK];
  assign oscillator_loss_indicator = s_q.s2[4];
  assign power_fault_indicator_a = s_q.pf[0];
  assign power_fault_indicator_b = s_q.pf[1];
  assign id_lamp = s_q.ctrl[RCC_CTRL_IDLAMP];
  assign aux_out = s_q.aux_o;
  assign aux_oe_n = s_q.aux_oe_n;

  // Assertions, all on the one clock and held off during reset
  default clocking rcc_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Arm request seen by an idle sequencer
  sequence arm_req_s;
    s_q.st == RCC_IDLE && s_q.ctrl[RCC_CTRL_ARM];
  endsequence
  // Address and data both held, commit happens on this edge
  sequence wr_go_s;
    s_q.awr && s_q.wr && !s_q.bv;
  endsequence

  armed_err_a: assert property (arm_req_s ##0 !cfg_ok |=>
    s_q.st == RCC_IDLE && s_q.cfgerr)
    else $error("armed with bad configuration");
  arm_ok_a: assert property (arm_req_s ##0
    (cfg_ok && !s_q.ctrl[RCC_CTRL_ABORT]) |=>
    s_q.st == RCC_PRE && armed_indicator && capture_en)
    else $error("good configuration not armed");
  pre_hold_a: assert property ((s_q.st == RCC_PRE) |->
    s_q.smp <= s_q.pre_s)
    else $error("pre-trigger count overran");
  no_early_trig_a: assert property ((s_q.st == RCC_PRE) |=>
    s_q.st != RCC_POST)
    else $error("trigger before pre-trigger done");
  pre_fixed_a: assert property ((s_q.st != RCC_IDLE &&
    $past(s_q.st) != RCC_IDLE) |-> $stable(s_q.pre_s))
    else $error("pre-trigger depth changed");
  pre_limit_a: assert property ((s_q.st != RCC_IDLE) |->
    (s_q.pre_s[3:0] == 4'h0 && s_q.pre_s <= s_q.len_s - RCC_PRE_MARGIN))
    else $error("pre-trigger depth out of range");
  len_limit_a: assert property ((s_q.st != RCC_IDLE) |->
    (s_q.len_s >= RCC_RLEN_MIN && s_q.len_s[4:0] == 5'h0))
    else $error("record length out of range");
  // A clear commits on the edge where both halves of a write are held
  pf_latch_a: assert property ((s_q.pf[0] && !(s_q.awr &&
    s_q.wr && !s_q.bv && s_q.awa == RCC_PFLT_OFF)) |=> s_q.pf[0])
    else $error("power fault dropped without clear");
  conf_hold_a: assert property (config_done_indicator |=>
    config_done_indicator)
    else $error("config done lamp dropped");
  // Lamp must follow the written mode bit, not just the stored copy
  clkmode_a: assert property (wr_go_s ##0 (s_q.ws == 4'hF &&
    s_q.awa == RCC_CTRL_OFF) |=>
    clock_mode_indicator != $past(s_q.wd[RCC_CTRL_EXTCLK]))
    else $error("clock mode lamp wrong");
  trig_idle_a: assert property ((s_q.st != RCC_POST) |=>
    !trigger_capture_indicator)
    else $error("trigger lamp lit outside post-trigger");
endmodule // rcc_capture_ctrl

// ===== testbench/rcc_src_model.sv
// Source model: continuous sample stream and selectable trigger levels
`timescale 1ns/1ns
module rcc_src_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Trigger command from the bench
  input wire logic [1:0] trig_sel,
  input wire logic trig_on,
  // Stream and trigger pins
  output logic sample_valid,
  output logic trig_cha,
  output logic trig_chb,
  output logic external_trigger_input
);
  // Free-running samples; a gated stream would stall the pre-trigger count
  always_ff @(posedge aclk) begin
    sample_valid <= aresetn;
    trig_cha <= trig_on && trig_sel == 2'h0;
    trig_chb <= trig_on && trig_sel == 2'h1;
    external_trigger_input <= trig_on && trig_sel == 2'h2;
  end
endmodule // rcc_src_model

// ===== testbench/rcc_capture_ctrl_tb_top.sv
// Testbench for record capture control: registers, capture and lamps
`timescale 1ns/1ns
module rcc_capture_ctrl_tb_top;
  import rcc_pkg::*;
  // Bench-driven pins, dut outputs and bookkeeping
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, sample_valid, trig_cha, trig_chb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, trig_sel = 2'h0;
  logic trig_on = 1'b0, external_trigger_input, aux_in = 1'b0;
  logic link_up_pin = 1'b0, osc_fault_pin = 1'b0;
  logic pwr_fault_a_pin = 1'b0, pwr_fault_b_pin = 1'b0;
  logic aux_out, aux_oe_n, capture_en, clock_mode_indicator, id_lamp;
  logic trigger_capture_indicator, clock_activity_indicator;
  logic armed_indicator, config_done_indicator, link_up_indicator;
  logic memory_ok_indicator, oscillator_loss_indicator;
  logic power_fault_indicator_a, power_fault_indicator_b;
  int bad_count = 0, tests_run = 0;
  // Limit table: length, depth, count, and which entries must be refused
  localparam logic [31:0] RL_T [7] = '{32'h60, 32'h90, 32'h80, 32'h80,
    32'h80, 32'h80, 32'hA0};
  localparam logic [31:0] PR_T [7] = '{32'h0, 32'h0, 32'h40, 32'h50,
    32'h8, 32'h0, 32'h60};
  localparam logic [31:0] CN_T [7] = '{32'h1, 32'h1, 32'h1, 32'h1,
    32'h1, 32'h0, 32'hFFFFFFFF};
  localparam logic [6:0] BAD_T = 7'b0111011;

  // Shortened timers keep both lamp counts visible in a short run
  rcc_capture_ctrl #(.CONF_CYC(8), .BLINK_CYC(4)) u_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .sample_valid, .trig_cha, .trig_chb,
    .external_trigger_input, .link_up_pin, .osc_fault_pin,
    .pwr_fault_a_pin, .pwr_fault_b_pin, .aux_in, .aux_out, .aux_oe_n,
    .capture_en, .clock_mode_indicator, .trigger_capture_indicator,
    .clock_activity_indicator, .armed_indicator, .config_done_indicator,
    .link_up_indicator, .memory_ok_indicator, .oscillator_loss_indicator,
    .power_fault_indicator_a, .power_fault_indicator_b, .id_lamp);
  rcc_src_model u_src (.aclk, .aresetn, .trig_sel, .trig_on,
    .sample_valid, .trig_cha, .trig_chb, .external_trigger_input);

  // 50 MHz clock
  always #10 aclk = ~aclk;

  // One comparison, reported at once on mismatch
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Write: address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // No cycle count assumed; only the watchdog ends a hung wait
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(32'({s_axi_bvalid, s_axi_bresp}), 32'h4);
  endtask
  // Read: rready held until the data is sampled
  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] exp);
    axi_rd(a);
    chk(rd & m, exp);
  endtask

  // Reset values, then an unmapped read that must answer with an error
  task automatic t_reset();
    rchk(RCC_RLEN_OFF, 32'hFFFFFFFF, RCC_RLEN_RST);
    rchk(RCC_RCNT_OFF, 32'hFFFFFFFF, RCC_RCNT_RST);
    rchk(RCC_PRE_OFF, 32'hFFFFFFFF, RCC_ZERO);
    // Aux resets to trigger output, so the pin is driven after reset
    chk(32'({aux_oe_n, clock_mode_indicator, capture_en}), 32'h2);
    rchk(8'h1C, 32'hFFFFFFFF, RCC_ZERO);
    chk(32'(rr), 32'h2);
  endtask
  // Boundary configurations: refused ones flag an error and stay idle
  task automatic t_limits();
    for (int i = 0; i < 7; i++) begin
      axi_wr(RCC_RLEN_OFF, RL_T[i]);
      axi_wr(RCC_PRE_OFF, PR_T[i]);
      axi_wr(RCC_RCNT_OFF, CN_T[i]);
      axi_wr(RCC_CTRL_OFF, 32'h61);
      tick(2);
      axi_rd(RCC_STAT_OFF);
      if (BAD_T[i]) chk(rd & 32'h5, 32'h4);
      else chk(rd & 32'h1, 32'h1);
      chk(32'(capture_en), 32'(!BAD_T[i]));
      axi_wr(RCC_CTRL_OFF, 32'h62);
    end
  endtask
  // Trigger held high: every record must still wait out its depth
  task automatic t_hold(input logic [1:0] src, input logic [31:0] pre,
      input logic [31:0] cnt);
    int low, rises, n;
    logic was;
    low = 0;
    rises = 0;
    n = 0;
    was = 1'b0;
    axi_wr(RCC_RLEN_OFF, RCC_RLEN_MIN);
    axi_wr(RCC_PRE_OFF, pre);
    axi_wr(RCC_RCNT_OFF, cnt);
    trig_sel <= src;
    trig_on <= 1'b1;
    axi_wr(RCC_CTRL_OFF, 32'({src, 5'h01}));
    do begin
      @(posedge aclk);
      n++;
      if (trigger_capture_indicator === 1'b1 && was === 1'b0) begin
        rises++;
        chk(32'(low >= pre), 32'h1);
        if (rises == 1) chk(32'(armed_indicator), 32'h1);
        low = 0;
      end else if (capture_en === 1'b1 && !trigger_capture_indicator) begin
        low++;
      end
      was = trigger_capture_indicator;
    end while ((capture_en === 1'b1 || n < 4) && n < 3000);
    trig_on <= 1'b0;
    chk(32'(rises), cnt);
    chk(32'({armed_indicator, trigger_capture_indicator}), 32'h0);
  endtask
  // Lamps: blink rate, config done, clock mode, id, memory, link, loss
  task automatic t_lamps();
    int flips;
    logic last;
    flips = 0;
    last = clock_activity_indicator;
    chk(32'({config_done_indicator, memory_ok_indicator}), 32'h2);
    repeat (16) begin
      @(posedge aclk);
      if (clock_activity_indicator !== last) flips++;
      last = clock_activity_indicator;
    end
    chk(32'(flips), 32'h4);
    axi_wr(RCC_CTRL_OFF, 32'h7C);
    link_up_pin <= 1'b1;
    osc_fault_pin <= 1'b1;
    tick(5);
    chk(32'({clock_mode_indicator, id_lamp, memory_ok_indicator}), 32'h3);
    chk(32'({link_up_indicator, oscillator_loss_indicator}), 32'h3);
    rchk(RCC_STAT_OFF, 32'h18, 32'h18);
    axi_wr(RCC_CTRL_OFF, 32'h60);
    osc_fault_pin <= 1'b0;
    tick(5);
    chk(32'({clock_mode_indicator, id_lamp, oscillator_loss_indicator,
      config_done_indicator}), 32'h9);
  endtask
  // Short fault pulses stay latched until written clear
  task automatic t_power();
    for (int i = 0; i < 2; i++) begin
      {pwr_fault_b_pin, pwr_fault_a_pin} <= 2'(1 << i);
      tick(4);
      {pwr_fault_b_pin, pwr_fault_a_pin} <= 2'h0;
      tick(6);
      chk(32'({power_fault_indicator_b, power_fault_indicator_a}),
        32'(1 << i));
      rchk(RCC_PFLT_OFF, 32'h3, 32'(1 << i));
      axi_wr(RCC_PFLT_OFF, 32'(1 << i));
      tick(2);
      chk(32'({power_fault_indicator_b, power_fault_indicator_a}),
        32'h0);
    end
  endtask
  // Every aux mode: drive direction and output level; input readback in the trigger-enable and input modes
  task automatic t_aux();
    int flips;
    logic last;
    for (int m = 0; m < 5; m++) begin
      axi_wr(RCC_AUX_OFF, 32'h0002_0008 | 32'(m));
      aux_in <= m[2];
      tick(5);
      chk(32'(aux_oe_n), 32'(m >= RCC_AUX_TRIGEN));
      // Pacer half of 2 flips the pin every third cycle
      if (m == 1) begin
        flips = 0;
        last = aux_out;
        repeat (12) begin
          @(posedge aclk);
          if (aux_out !== last) flips++;
          last = aux_out;
        end
        chk(32'(flips), 32'h4);
      end else chk(32'(aux_out), 32'(m == 2));
      if (m >= RCC_AUX_TRIGEN) rchk(RCC_STAT_OFF, 32'h20, 32'(m[2]) << 5);
    end
  endtask

  // Verdict and end of run
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Main sequence after five reset cycles
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_limits();
    t_hold(RCC_TS_EXT, 32'h40, 32'h1);
    t_hold(RCC_TS_CHB, 32'h20, 32'h3);
    t_lamps();
    t_power();
    t_aux();
    close_out();
  end
  // Watchdog well beyond the expected thousand or so cycles
  initial begin
    #1_000_000;
    bad_count++;
    close_out();
  end
endmodule // rcc_capture_ctrl_tb_top
